// file: logic/ptu_regs.vh
// Function
// - Timer base clock is divided by four to clock the 8-bit counter.
// - While enabled, counter counts 0x00 up to 0xff, wraps, continues.
// - Timeout sets interrupt flag itself; accepted interrupt vectors to 0x04.
// - Timer interrupt reaches CPU only with timer and global enables set.
// - Writing zero to control bit 7 clears counter; bit returns to one.
// - Control bit 3 starts counting when set, stops it when cleared.
// - Count value readable in read-only register, zero after reset, writes ignored.
// - At 1024 Hz base, bit 0 gives 1/128 s, doubling to 1 s.
// - Source bit zero picks system clock over 1000, one picks external/32.
// - Divide bit zero: system clock is master; one: master over four.
// - Oscillator bit picks internal or external clock, external optionally halved.
// - Counter A readable as two read-only bytes, high and low.
// - Ultimate source is internal 1 MHz or external 32768 Hz oscillator.
`ifndef PTU_REGS_VH
`define PTU_REGS_VH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define PTU_IDX_STATUS   6'h04
`define PTU_IDX_INTERRUPT_FLAGS     6'h06
`define PTU_IDX_INTE     6'h07
`define PTU_IDX_CTA_HI   6'h08
`define PTU_IDX_CTA_LO   6'h09
`define PTU_IDX_CTB_HI   6'h0a
`define PTU_IDX_CTB_LO   6'h0b
`define PTU_IDX_CTCTL    6'h0c
`define PTU_IDX_WDCTL    6'h0d
`define PTU_IDX_COUNT    6'h0e
`define PTU_IDX_TMCTL    6'h0f
`define PTU_IDX_CLKSEL   6'h14
`define PTU_IDX_IRQ_STAT 6'h30
`define PTU_IDX_IRQ_CLR  6'h31
`define PTU_IDX_IRQ_EN   6'h32

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define PTU_TMCTL_RESET_BIT 7
`define PTU_TMCTL_RUN_BIT   3
`define PTU_INTERRUPT_FLAGS_TIMER_BIT  4
`define PTU_INTE_GLOBAL_BIT 7
`define PTU_INTE_TIMER_BIT  4
`define PTU_CLK_SRC_BIT     5
`define PTU_CLK_HALVE_BIT   3
`define PTU_CLK_SYSDIV_BIT  1
`define PTU_CLK_OSC_BIT     0
`define PTU_IRQ_TIMEOUT     0
`define PTU_IRQ_WRAP        1

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define PTU_TMCTL_RST  8'h80
`define PTU_COUNT_RST  8'h00
`define PTU_INTERRUPT_FLAGS_RST   8'h00
`define PTU_INTE_RST   8'h00
`define PTU_CLKSEL_RST 8'h00
`define PTU_CTCTL_RST  8'h00
`define PTU_WDCTL_RST  8'h00

// ------------------------------------------------------------
// Clock division counts and interrupt vector
// ------------------------------------------------------------
`define PTU_PRESCALE   4
`define PTU_SYSDIV     4
`define PTU_SYS_BASE   1000
`define PTU_EXT_BASE   32
`define PTU_IRQ_VECTOR 8'h04

`endif

// file: logic/ptu_timer.v
`include "ptu_regs.vh"

module ptu_timer #(
    parameter PRESCALE_DIV = `PTU_PRESCALE,
    parameter SYSDIV_DIV   = `PTU_SYSDIV,
    parameter SYS_BASE_DIV = `PTU_SYS_BASE,
    parameter EXT_BASE_DIV = `PTU_EXT_BASE
) (
    input  wire        mclk_i,
    input  wire        reset_n_i,
    input  wire        ce_i,
    input  wire        int_osc_i,
    input  wire        ext_osc_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [7:0]  paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    output reg         cpu_irq_o,
    output reg  [7:0]  irq_vector_o,
    output reg         irq_o
);

    // ------------------------------------------------------------
    // Divider terminal counts
    // ------------------------------------------------------------
    // Counter widths cap the ratios at 4, 4, 1024 and 32
    localparam [31:0] PRE_LAST_W    = PRESCALE_DIV - 1;
    localparam [31:0] SYSDIV_LAST_W = SYSDIV_DIV - 1;
    localparam [31:0] SYS_LAST_W    = SYS_BASE_DIV - 1;
    localparam [31:0] EXT_LAST_W    = EXT_BASE_DIV - 1;
    localparam [1:0]  PRE_LAST      = PRE_LAST_W[1:0];
    localparam [1:0]  SYSDIV_LAST   = SYSDIV_LAST_W[1:0];
    localparam [9:0]  SYS_LAST      = SYS_LAST_W[9:0];
    localparam [4:0]  EXT_LAST      = EXT_LAST_W[4:0];

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    reg  [7:0]  tmctl_r;
    reg  [7:0]  count_r;
    reg  [7:0]  interrupt_flags_r;
    reg  [7:0]  inte_r;
    reg  [7:0]  clksel_r;
    reg  [7:0]  ctctl_r;
    reg  [7:0]  wdctl_r;
    reg  [15:0] cta_r;
    reg  [15:0] ctb_r;
    reg  [1:0]  irq_stat_r;
    reg  [1:0]  irq_en_r;

    // ------------------------------------------------------------
    // Clock chain state
    // ------------------------------------------------------------
    reg         int_osc_q_r;
    reg         ext_osc_q_r;
    reg         halve_r;
    reg  [1:0]  sysdiv_r;
    reg  [9:0]  sysbase_r;
    reg  [4:0]  extbase_r;
    reg  [1:0]  prescale_r;
    reg         sel_bit_q_r;

    wire        int_rise;
    wire        ext_rise;
    wire        master_tick;
    wire        sys_tick;
    wire        base_tick;
    wire        count_tick;
    wire        sel_bit;
    wire        timeout_evt;
    wire        wrap_evt;
    wire        run;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire [5:0]  idx      = paddr_i[7:2];
    wire        acc      = psel_i & penable_i;
    wire        wr_now   = acc & pready_o & pwrite_i & ~pslverr_o;
    wire [7:0]  wd       = pwdata_i[7:0];
    reg  [7:0]  rd_nxt;
    reg         hit_nxt;

    // ------------------------------------------------------------
    // Oscillator edge detection
    // ------------------------------------------------------------
    // Both oscillators are far slower than mclk, so one edge each
    assign int_rise = int_osc_i & ~int_osc_q_r;
    assign ext_rise = ext_osc_i & ~ext_osc_q_r;

    // Master clock source, external optionally halved
    assign master_tick = clksel_r[`PTU_CLK_OSC_BIT] ?
                         (ext_rise & (~clksel_r[`PTU_CLK_HALVE_BIT] | halve_r)) :
                         int_rise;

    // System clock: master or master over four
    assign sys_tick = master_tick &
                      (~clksel_r[`PTU_CLK_SYSDIV_BIT] | (sysdiv_r == SYSDIV_LAST));

    // Base clock: system/1000 or external/32
    assign base_tick = clksel_r[`PTU_CLK_SRC_BIT] ?
                       (ext_rise & (extbase_r == EXT_LAST)) :
                       (sys_tick & (sysbase_r == SYS_LAST));

    // One count every fourth base tick
    assign count_tick = base_tick & (prescale_r == PRE_LAST);

    // Counting needs run bit set and reset bit released
    assign run = tmctl_r[`PTU_TMCTL_RUN_BIT] & tmctl_r[`PTU_TMCTL_RESET_BIT];

    // Selector code n picks counter bit n
    assign sel_bit = count_r[tmctl_r[2:0]];

    // Rising edge only: a held-high bit yields no repeats
    // A selector change onto a high bit also counts as an edge
    assign timeout_evt = sel_bit & ~sel_bit_q_r & run;
    assign wrap_evt    = count_tick & run & (count_r == 8'hff);

    // ------------------------------------------------------------
    // Clock chain counters
    // ------------------------------------------------------------
    // Oscillator levels of the last edge, for the edge detectors
    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            int_osc_q_r <= 1'b0;
            ext_osc_q_r <= 1'b0;
        end else if (ce_i) begin
            int_osc_q_r <= int_osc_i;
            ext_osc_q_r <= ext_osc_i;
        end
    end

    // Halving toggle: every other external edge reaches the master
    always @(posedge mclk_i) begin
        if (!reset_n_i)
            halve_r <= 1'b0;
        else if (ce_i & ext_rise)
            halve_r <= ~halve_r;
    end

    // System divider steps on every master tick
    always @(posedge mclk_i) begin
        if (!reset_n_i)
            sysdiv_r <= 2'd0;
        else if (ce_i & master_tick)
            sysdiv_r <= (sysdiv_r == SYSDIV_LAST) ? 2'd0 : sysdiv_r + 2'd1;
    end

    // Free-running: a timer reset does not realign the base clock
    always @(posedge mclk_i) begin
        if (!reset_n_i)
            sysbase_r <= 10'd0;
        else if (ce_i & sys_tick)
            sysbase_r <= (sysbase_r == SYS_LAST) ? 10'd0 : sysbase_r + 10'd1;
    end

    // External base divider, also free-running
    always @(posedge mclk_i) begin
        if (!reset_n_i)
            extbase_r <= 5'd0;
        else if (ce_i & ext_rise)
            extbase_r <= (extbase_r == EXT_LAST) ? 5'd0 : extbase_r + 5'd1;
    end

    // Prescaler restarts with the counter so a first count is whole
    always @(posedge mclk_i) begin
        if (!reset_n_i)
            prescale_r <= 2'd0;
        else if (ce_i) begin
            if (!tmctl_r[`PTU_TMCTL_RESET_BIT])
                prescale_r <= 2'd0;
            else if (base_tick)
                prescale_r <= (prescale_r == PRE_LAST) ? 2'd0 : prescale_r + 2'd1;
        end
    end

    // ------------------------------------------------------------
    // Timer counter and timeout edge
    // ------------------------------------------------------------
    // Counter: a reset-bit zero beats a same-cycle count tick
    always @(posedge mclk_i) begin
        if (!reset_n_i)
            count_r <= `PTU_COUNT_RST;
        else if (ce_i) begin
            if (!tmctl_r[`PTU_TMCTL_RESET_BIT])
                count_r <= 8'h00;
            else if (run & count_tick)
                count_r <= count_r + 8'd1;              // wraps past 0xff
        end
    end

    // Last level of the selected bit, for the rising-edge test
    always @(posedge mclk_i) begin
        if (!reset_n_i)
            sel_bit_q_r <= 1'b0;
        else if (ce_i)
            sel_bit_q_r <= sel_bit;
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    // Unlisted or misaligned index: error answer, reads zero
    always @* begin
        rd_nxt  = 8'h00;
        hit_nxt = 1'b1;
        if (paddr_i[1:0] != 2'b00)
            hit_nxt = 1'b0;
        else if (idx == `PTU_IDX_STATUS)
            rd_nxt = 8'h00;                             // Watchdog flag not modelled
        else if (idx == `PTU_IDX_INTERRUPT_FLAGS)
            rd_nxt = interrupt_flags_r;
        else if (idx == `PTU_IDX_INTE)
            rd_nxt = inte_r;
        else if (idx == `PTU_IDX_CTA_HI)
            rd_nxt = cta_r[15:8];
        else if (idx == `PTU_IDX_CTA_LO)
            rd_nxt = cta_r[7:0];
        else if (idx == `PTU_IDX_CTB_HI)
            rd_nxt = ctb_r[15:8];
        else if (idx == `PTU_IDX_CTB_LO)
            rd_nxt = ctb_r[7:0];
        else if (idx == `PTU_IDX_CTCTL)
            rd_nxt = {ctctl_r[7:1], 1'b0};
        else if (idx == `PTU_IDX_WDCTL)
            rd_nxt = {wdctl_r[7], 4'h0, wdctl_r[2:0]};
        else if (idx == `PTU_IDX_COUNT)
            rd_nxt = count_r;
        else if (idx == `PTU_IDX_TMCTL)
            rd_nxt = {tmctl_r[7], 3'b000, tmctl_r[3:0]};
        else if (idx == `PTU_IDX_CLKSEL)
            rd_nxt = {clksel_r[7:5], 1'b0, clksel_r[3:0]};
        else if (idx == `PTU_IDX_IRQ_STAT)
            rd_nxt = {6'h00, irq_stat_r};
        else if (idx == `PTU_IDX_IRQ_CLR)
            rd_nxt = 8'h00;                             // Write-only
        else if (idx == `PTU_IDX_IRQ_EN)
            rd_nxt = {6'h00, irq_en_r};
        else
            hit_nxt = 1'b0;
    end

    // ------------------------------------------------------------
    // APB slave: one wait state so every output is registered
    // ------------------------------------------------------------
    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else if (ce_i) begin
            if (acc & ~pready_o) begin
                pready_o  <= 1'b1;
                pslverr_o <= ~hit_nxt;
                prdata_o  <= {24'h00_0000, rd_nxt};
            end else begin
                pready_o  <= 1'b0;
                pslverr_o <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Control registers written by software
    // ------------------------------------------------------------
    // Reset bit springs back to one a cycle after a zero write
    always @(posedge mclk_i) begin
        if (!reset_n_i)
            tmctl_r <= `PTU_TMCTL_RST;
        else if (ce_i) begin
            if (wr_now & (idx == `PTU_IDX_TMCTL))
                tmctl_r <= {wd[7], 3'b000, wd[3:0]};
            else if (!tmctl_r[`PTU_TMCTL_RESET_BIT])
                tmctl_r[`PTU_TMCTL_RESET_BIT] <= 1'b1;
        end
    end

    // Plain read/write control bytes
    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            inte_r   <= `PTU_INTE_RST;
            clksel_r <= `PTU_CLKSEL_RST;
            ctctl_r  <= `PTU_CTCTL_RST;
            wdctl_r  <= `PTU_WDCTL_RST;
            irq_en_r <= 2'b00;
        end else if (ce_i) begin
            if (wr_now & (idx == `PTU_IDX_INTE))
                inte_r <= wd;
            if (wr_now & (idx == `PTU_IDX_CLKSEL))
                clksel_r <= wd;
            if (wr_now & (idx == `PTU_IDX_CTCTL))
                ctctl_r <= wd;
            if (wr_now & (idx == `PTU_IDX_WDCTL))
                wdctl_r <= wd;
            if (wr_now & (idx == `PTU_IDX_IRQ_EN))
                irq_en_r <= wd[1:0];
        end
    end

    // Counter A mirrors counter B when B is loaded; it never counts here
    always @(posedge mclk_i) begin
        if (!reset_n_i) begin
            ctb_r <= 16'h0000;
            cta_r <= 16'h0000;
        end else if (ce_i) begin
            if (wr_now & (idx == `PTU_IDX_CTB_HI)) begin
                ctb_r[15:8] <= wd;
                cta_r[15:8] <= wd;
            end
            if (wr_now & (idx == `PTU_IDX_CTB_LO)) begin
                ctb_r[7:0] <= wd;
                cta_r[7:0] <= wd;
            end
        end
    end

    // ------------------------------------------------------------
    // Flags: hardware set wins over a same-cycle software clear
    // ------------------------------------------------------------
    // Timer flag in the CPU flag register
    always @(posedge mclk_i) begin
        if (!reset_n_i)
            interrupt_flags_r <= `PTU_INTERRUPT_FLAGS_RST;
        else if (ce_i) begin
            if (wr_now & (idx == `PTU_IDX_INTERRUPT_FLAGS))
                interrupt_flags_r <= wd;
            if (timeout_evt)
                interrupt_flags_r[`PTU_INTERRUPT_FLAGS_TIMER_BIT] <= 1'b1;
        end
    end

    // Sticky status behind the level interrupt output
    always @(posedge mclk_i) begin
        if (!reset_n_i)
            irq_stat_r <= 2'b00;
        else if (ce_i) begin
            if (wr_now & (idx == `PTU_IDX_IRQ_CLR))
                irq_stat_r <= irq_stat_r & ~wd[1:0];
            if (timeout_evt)
                irq_stat_r[`PTU_IRQ_TIMEOUT] <= 1'b1;
            if (wrap_evt)
                irq_stat_r[`PTU_IRQ_WRAP] <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Interrupt outputs
    // ------------------------------------------------------------
    // Registered, so the CPU line lags the flag by one cycle
    always @(posedge mclk_i) begin
        if (!reset_n_i)
            cpu_irq_o <= 1'b0;
        else if (ce_i)
            cpu_irq_o <= interrupt_flags_r[`PTU_INTERRUPT_FLAGS_TIMER_BIT] &
                         inte_r[`PTU_INTE_TIMER_BIT] &
                         inte_r[`PTU_INTE_GLOBAL_BIT];
    end

    // Level output: any enabled sticky status bit
    always @(posedge mclk_i) begin
        if (!reset_n_i)
            irq_o <= 1'b0;
        else if (ce_i)
            irq_o <= |(irq_stat_r & irq_en_r);
    end

    // Fixed vector, kept in a flop like every other output
    always @(posedge mclk_i) begin
        if (!reset_n_i)
            irq_vector_o <= `PTU_IRQ_VECTOR;
        else if (ce_i)
            irq_vector_o <= `PTU_IRQ_VECTOR;
    end

endmodule

// file: bench/ptu_timer_monitor.sv
module ptu_timer_monitor (
    input wire        mclk_i,
    input wire        reset_n_i,
    input wire        psel_i,
    input wire        penable_i,
    input wire        pwrite_i,
    input wire [7:0]  paddr_i,
    input wire [31:0] prdata_o,
    input wire        pready_o,
    input wire        pslverr_o,
    input wire        cpu_irq_o,
    input wire [7:0]  irq_vector_o,
    input wire        irq_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    // ----------------------------------------
    // Access phase tracking
    // ----------------------------------------
    // Later edges of a waited access must not count as a new request
    reg  acc_r;
    wire acc_first = psel_i && penable_i && !acc_r;
    wire wr_done   = pready_o && pwrite_i;
    always @(posedge mclk_i) begin
        acc_r <= reset_n_i && psel_i && penable_i;
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    a_ready_time: assert property (acc_first |=> pready_o)
        else $error("answer not one cycle after access start");
    a_ready_cause: assert property (pready_o |-> psel_i && penable_i && acc_r)
        else $error("answer without a waited access");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("answer held too long");
    a_err_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without answer");
    a_err_misalign: assert property (acc_first && paddr_i[1:0] != 2'b00 |=> pslverr_o)
        else $error("misaligned access not refused");
    a_ro_write_ok: assert property (acc_first && pwrite_i && paddr_i == 8'h38
        |=> pready_o && !pslverr_o)
        else $error("count register write refused");
    a_rdata_upper: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
        else $error("upper read lanes not zero");
    a_vector_fixed: assert property (irq_vector_o == 8'h04)
        else $error("vector not fixed");
    a_reset_quiet: assert property ($rose(reset_n_i) |-> !cpu_irq_o && !irq_o)
        else $error("interrupt active after reset");
    a_flag_drop: assert property ($fell(cpu_irq_o) |->
        $past(wr_done, 1) || $past(wr_done, 2))
        else $error("cpu interrupt fell without software write");
    a_irq_drop: assert property ($fell(irq_o) |->
        $past(wr_done, 1) || $past(wr_done, 2))
        else $error("interrupt fell without software write");
    c_refused: cover property (pready_o && pslverr_o);
    c_cpu_irq: cover property ($rose(cpu_irq_o));
    c_irq: cover property ($rose(irq_o));
endmodule

bind ptu_timer ptu_timer_monitor u_mon (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .cpu_irq_o(cpu_irq_o), .irq_vector_o(irq_vector_o), .irq_o(irq_o));

// file: bench/tb_top.sv
`include "ptu_regs.vh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam [7:0] A_TCTL = {`PTU_IDX_TMCTL, 2'b00};
    localparam [7:0] A_CNT  = {`PTU_IDX_COUNT, 2'b00};
    localparam [7:0] A_CLK  = {`PTU_IDX_CLKSEL, 2'b00};
    localparam [7:0] A_IST  = {`PTU_IDX_IRQ_STAT, 2'b00};
    localparam [7:0] A_ICL  = {`PTU_IDX_IRQ_CLR, 2'b00};
    localparam [7:0] A_IEN  = {`PTU_IDX_IRQ_EN, 2'b00};
    localparam [7:0] A_FLG  = 8'h18;
    localparam [7:0] A_ENB  = 8'h1c;
    logic        mclk = 0, reset_n = 0, ce = 1, osc_i = 0, osc_e = 0;
    logic        psel = 0, penable = 0, pwrite = 0, e;
    logic [7:0]  paddr = 0, sel;
    logic [31:0] pwdata = 0, r;
    wire  [31:0] prdata;
    wire  [7:0]  vec;
    wire         pready, pslverr, cpu_irq, irq;
    int          bad_count = 0, checked = 0;
    logic [7:0]  en_tab [3] = '{8'h10, 8'h80, 8'h90};

    always #20 mclk = ~mclk;

    ptu_timer u_dut (.mclk_i(mclk), .reset_n_i(reset_n), .ce_i(ce), .int_osc_i(osc_i),
        .ext_osc_i(osc_e), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .cpu_irq_o(cpu_irq), .irq_vector_o(vec), .irq_o(irq));

    // ----------------------------------------
    // Bus and stimulus tasks
    // ----------------------------------------
    // Waits for the answer however long it takes; the watchdog bounds a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd_o, output logic err_o);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd_o = prdata;
        err_o = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] x, input string nm);
        logic [31:0] v;
        logic        er;
        apb(1'b0, a, 32'h0, v, er);
        `CHK(nm, {24'h0, x}, v)
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] v;
        logic        er;
        apb(1'b1, a, {24'h0, d}, v, er);
    endtask

    // Both oscillators pulse together; the source select decides which counts
    task automatic osc(input int n);
        repeat (n) begin
            @(posedge mclk);
            osc_i <= 1'b1;
            osc_e <= 1'b1;
            @(posedge mclk);
            osc_i <= 1'b0;
            osc_e <= 1'b0;
        end
    endtask

    // Interrupt outputs are registered behind the written register
    task automatic settle();
        repeat (2) @(posedge mclk);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        rd(A_TCTL, 8'h80, "ctl reset");
        rd(A_CNT, 8'h00, "count reset");
        rd(A_FLG, 8'h00, "flags reset");
        rd(A_ENB, 8'h00, "enables reset");
        wr(A_CNT, 8'h5a);
        rd(A_CNT, 8'h00, "count read only");
        apb(1'b0, 8'hfc, 32'h0, r, e);
        `CHK("unmapped err", 1'b1, e)
        apb(1'b0, 8'h3d, 32'h0, r, e);
        `CHK("misaligned err", 1'b1, e)
        `CHK("vector", 8'h04, vec)
        $display("test registers done");
        wr(A_CLK, 8'h20);
        wr(A_ENB, 8'h90);
        for (int n = 0; n < 3; n++) begin
            sel = 8'(n);
            wr(A_TCTL, 8'h88 | sel);
            wr(A_TCTL, 8'h08 | sel);
            wr(A_FLG, 8'h00);
            rd(A_TCTL, 8'h88 | sel, "reset bit back");
            osc((128 << n) - 1);
            rd(A_FLG, 8'h00, "early flag");
            osc(1);
            rd(A_CNT, 8'h01 << n, "count");
            rd(A_FLG, 8'h10, "timeout flag");
            `CHK("cpu irq", 1'b1, cpu_irq)
        end
        for (int i = 0; i < 3; i++) begin
            wr(A_ENB, en_tab[i]);
            settle();
            `CHK("irq gate", (i == 2), cpu_irq)
        end
        wr(A_FLG, 8'h00);
        settle();
        `CHK("flag cleared", 1'b0, cpu_irq)
        wr(A_TCTL, 8'h82);
        osc(256);
        rd(A_CNT, 8'h04, "stopped");
        $display("test timeout done");
        wr(A_ICL, 8'h03);
        wr(A_IEN, 8'h01);
        wr(A_TCTL, 8'h88);
        wr(A_TCTL, 8'h08);
        osc(128);
        rd(A_IST, 8'h01, "irq status");
        `CHK("irq on", 1'b1, irq)
        wr(A_IEN, 8'h00);
        settle();
        `CHK("irq masked", 1'b0, irq)
        wr(A_IEN, 8'h01);
        settle();
        `CHK("irq unmasked", 1'b1, irq)
        wr(A_ICL, 8'h01);
        settle();
        `CHK("irq cleared", 1'b0, irq)
        rd(A_IST, 8'h00, "status cleared");
        osc(255 * 128);
        rd(A_CNT, 8'h00, "wrapped count");
        rd(A_IST, 8'h03, "wrap status");
        $display("test interrupt done");
        // Base dividers run free; a mid-run reset gives them a known phase
        reset_n <= 1'b0;
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        rd(A_TCTL, 8'h80, "ctl after reset");
        `CHK("cpu irq after reset", 1'b0, cpu_irq)
        `CHK("irq after reset", 1'b0, irq)
        wr(A_CLK, 8'h00);
        wr(A_TCTL, 8'h88);
        wr(A_TCTL, 8'h08);
        osc(3999);
        rd(A_CNT, 8'h00, "internal early");
        osc(1);
        rd(A_CNT, 8'h01, "internal count");
        $display("test internal done");
        wrap_up();
    end

    // Run needs about 76k cycles; cut off a hang at 90k
    initial begin
        #3_600_000;
        bad_count++;
        wrap_up();
    end
endmodule
